//--- sfe_pkg.sv
// shared constants for the sensor front-end output control block
package sfe_pkg;
   localparam int CLK_PERIOD_PS = 8000;
   // bridge sample periods per integration length, in picoseconds
   localparam longint PERIOD_INT10_PS = 64'd1666666667;
   localparam longint PERIOD_INT9_PS  = 64'd884955752;
   localparam longint PERIOD_INT8_PS  = 64'd492610837;
   localparam longint PERIOD_INT7_PS  = 64'd393700787;
   localparam int CYC_INT10 = int'(PERIOD_INT10_PS / CLK_PERIOD_PS);
   localparam int CYC_INT9  = int'(PERIOD_INT9_PS / CLK_PERIOD_PS);
   localparam int CYC_INT8  = int'(PERIOD_INT8_PS / CLK_PERIOD_PS);
   localparam int CYC_INT7  = int'(PERIOD_INT7_PS / CLK_PERIOD_PS);

   localparam logic [7:0] OFS_CFG   = 8'h00;
   localparam logic [7:0] OFS_DOFS  = 8'h04;
   localparam logic [7:0] OFS_STAT  = 8'h08;
   localparam logic [7:0] OFS_SHIFT = 8'h0c;
   localparam logic [7:0] OFS_RDBR  = 8'h10;
   localparam logic [7:0] OFS_RDTMP = 8'h14;
   localparam logic [7:0] OFS_RDHB  = 8'h18;

   // configuration, status and shift word field positions
   localparam int CFG_GAIN_LSB  = 0;
   localparam int CFG_XZC_LSB   = 4;
   localparam int CFG_INT_LSB   = 10;
   localparam int CFG_RANGE_LSB = 12;
   localparam int CFG_SRC_LSB   = 14;
   localparam int CFG_SEQHB_BIT = 16;
   localparam int CFG_FILT1_BIT = 17;
   localparam int CFG_FILT2_BIT = 18;
   localparam int CFG_DIAG1_BIT = 19;
   localparam int CFG_DIAG2_BIT = 20;
   localparam int STAT_STEP_LSB = 16;
   localparam int SHIFT_STEP_LSB = 16;

   localparam logic [3:0] GAIN_LAST    = 4'hc;
   localparam logic signed [5:0] XZC_MAX = 6'sh1f;
   localparam logic signed [5:0] XZC_MIN = -6'sh1f;
   localparam logic [14:0] VALUE_MAX   = 15'h7fff;
   localparam logic [14:0] FAULT_LOW   = 15'h0000;
   localparam logic [14:0] FAULT_HIGH  = 15'h7fff;
   localparam int READOUT_DROP = 2;

   typedef enum logic [1:0] {
      SRC_TEMP, SRC_HALF, SRC_BRIDGE_FN, SRC_SEQ
   } out2_src_type;
   typedef enum logic [1:0] {
      INT_10, INT_9, INT_8, INT_7
   } integ_len_type;
endpackage : sfe_pkg

//--- out_chan_if.sv
// signals between the top and one analog output channel
`timescale 1ns/10ps
interface out_chan_if;
   logic [14:0] sample;
   logic        sampleValid;
   logic        filtEn;
   logic        diagEn;
   logic        faultActive;
   logic [14:0] faultLevel;
   logic [14:0] level;
   modport ctrl (output sample, sampleValid, filtEn, diagEn, faultActive,
                 faultLevel, input level);
   modport chan (input sample, sampleValid, filtEn, diagEn, faultActive,
                 faultLevel, output level);
endinterface : out_chan_if

//--- out_channel.sv
// one analog output channel: low-pass filter, power-on waveform, fault band
`timescale 1ns/10ps
module out_channel #(
   parameter int FILT_SHIFT = 3,
   parameter int DIAG_CYC   = 64
) (
   input  wire logic core_clk,
   input  wire logic arst_n,
   input  wire logic ce,
   out_chan_if.chan  ch
);
   typedef enum logic [1:0] {DG_LOW, DG_HIGH, DG_RUN} diag_type;
   diag_type diag_q;
   logic [15:0] diagCnt_q;
   logic [14:0] filt_q;
   logic signed [16:0] diff;

   assign diff = $signed({2'b00, ch.sample}) - $signed({2'b00, filt_q});

   // power-on diagnostic waveform: low level, high level, then signal
   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         diag_q    <= DG_LOW;
         diagCnt_q <= 16'h0000;
      end else if (ce && diag_q != DG_RUN) begin
         // enable read late so a quick post-reset write still counts
         if (!ch.diagEn && diag_q == DG_HIGH) begin
            diag_q <= DG_RUN;
         end else if (diagCnt_q == 16'(DIAG_CYC - 1)) begin
            diagCnt_q <= 16'h0000;
            diag_q    <= (diag_q == DG_LOW && ch.diagEn) ? DG_HIGH : DG_RUN;
         end else begin
            diagCnt_q <= diagCnt_q + 16'h0001;
         end
      end
   end

   // first-order low-pass, bypassed when disabled
   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         filt_q <= 15'h0000;
      end else if (ce && ch.sampleValid) begin
         if (ch.filtEn) begin
            filt_q <= 15'(filt_q + 15'(diff >>> FILT_SHIFT));
         end else begin
            filt_q <= ch.sample;
         end
      end
   end

   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         ch.level <= sfe_pkg::FAULT_LOW;
      end else if (ce) begin
         if (ch.faultActive) begin
            ch.level <= ch.faultLevel;
         end else begin
            case (diag_q)
               DG_LOW:  ch.level <= ch.diagEn ? sfe_pkg::FAULT_LOW : filt_q;
               DG_HIGH: ch.level <= sfe_pkg::FAULT_HIGH;
               DG_RUN:  ch.level <= filt_q;
               default: ch.level <= filt_q;
            endcase
         end
      end
   end

   // [RULE_13] power-on waveform
   chk_diag_high_phase: assert property (@(posedge core_clk) disable iff (!arst_n)
      ce && diag_q == DG_HIGH && !ch.faultActive |=> ch.level == sfe_pkg::FAULT_HIGH)
      else $error("diagnostic high phase not shown");
   // [RULE_12] filter bypass
   chk_filter_bypass: assert property (@(posedge core_clk) disable iff (!arst_n)
      ce && ch.sampleValid && !ch.filtEn |=> filt_q == $past(ch.sample))
      else $error("unfiltered sample not taken");
endmodule : out_channel

//--- sensor_frontend_output_control.sv
// configuration, sequencing and output control of the sensor front end
// Notes on behaviour
// [RULE_01] thirteen gain settings, 420 down to 2.8
// [RULE_02] offset step count clamped to plus/minus 31
// [RULE_03] per-step shift depends on selected gain
// [RULE_04] compensation reaches beyond 300 percent of span
// [RULE_05] digital offset correction of conditioned bridge
// [RULE_06] 14-bit second-order converter result kept
// [RULE_07] integration 10..7 bits sets sample rate
// [RULE_08] converter input range is configurable
// [RULE_09] primary output always carries conditioned bridge
// [RULE_10] secondary output picks one of four sources
// [RULE_11] sequence: low, high, temp/half, bridge function
// [RULE_12] optional low-pass filtering per output
// [RULE_13] optional power-on diagnostic waveform per output
// [RULE_14] signals readable with 13-bit resolution
// [RULE_15] user keeps amplifier within 10..90 percent
// [RULE_16] polarity pin open selects low fault level
// [RULE_17] conditioned results are 15-bit, zero to one
// [RULE_18] sequence repeats while sequential mode selected
//
// The placing of the registers and the AHB-Lite interface to the registers were chosen for this implementation.
`timescale 1ns/10ps
module sensor_frontend_output_control #(
   parameter int CYC_INT10  = sfe_pkg::CYC_INT10,
   parameter int CYC_INT9   = sfe_pkg::CYC_INT9,
   parameter int CYC_INT8   = sfe_pkg::CYC_INT8,
   parameter int CYC_INT7   = sfe_pkg::CYC_INT7,
   parameter int SEQ_SLOT   = 1024,
   parameter int FILT_SHIFT = 3,
   parameter int DIAG_CYC   = 1024
) (
   input  wire logic        core_clk,
   input  wire logic        arst_n,
   input  wire logic        ce,
   input  wire logic        hsel,
   input  wire logic [31:0] haddr,
   input  wire logic [1:0]  htrans,
   input  wire logic        hwrite,
   input  wire logic [2:0]  hsize,
   input  wire logic [31:0] hwdata,
   input  wire logic        hready,
   output logic             hreadyout,
   output logic             hresp,
   output logic [31:0]      hrdata,
   input  wire logic [14:0] bridgeIn,
   input  wire logic        bridgeValid,
   input  wire logic [14:0] tempIn,
   input  wire logic        tempValid,
   input  wire logic [14:0] halfIn,
   input  wire logic        halfValid,
   input  wire logic [13:0] adcRaw,
   input  wire logic        adcValid,
   input  wire logic        faultActive,
   input  wire logic        fault_band_polarity_pin,
   output logic [3:0]       gainSel,
   output logic [5:0]       extendedOffsetComp,
   output logic [1:0]       integLen,
   output logic [1:0]       adcRange,
   output logic             convStart,
   output logic [14:0]      primary_analog_out,
   output logic [14:0]      secondary_analog_out
);
   typedef enum logic [1:0] {SQ_LOW, SQ_HIGH, SQ_SECOND, SQ_BRIDGE}
      seq_type;

   // saturate bridge minus signed offset into [0, 1)
   function automatic logic [14:0] applyOffset(input logic [14:0] v,
                                               input logic [15:0] ofs);
      logic signed [17:0] s;
      s = $signed({3'b000, v}) - $signed({{2{ofs[15]}}, ofs});
      if (s < 0) begin
         return 15'h0000;
      end else if (s > $signed({3'b000, sfe_pkg::VALUE_MAX})) begin
         return sfe_pkg::VALUE_MAX;
      end
      return s[14:0];
   endfunction : applyOffset

   // shift per step in hundredths of a percent of span, by gain index
   function automatic logic [15:0] stepShift(input logic [3:0] g);
      case (g)
         4'h0, 4'h2, 4'h4, 4'h6, 4'h9: return 16'h04e2;
         4'h1, 4'h3, 4'h5, 4'h7, 4'ha: return 16'h02f8;
         4'h8, 4'hb:                   return 16'h0208;
         4'hc:                         return 16'h0053;
         default:                      return 16'h0053;
      endcase
   endfunction : stepShift

   function automatic logic [31:0] readout13(input logic [14:0] v);
      return {19'h00000, v[14:sfe_pkg::READOUT_DROP]};
   endfunction : readout13

   out_chan_if ch1 ();
   out_chan_if ch2 ();

   logic [31:0] cfg_q;
   logic [15:0] dofs_q;
   logic [13:0] adcLast_q;
   logic [14:0] bridge_q;
   logic [14:0] temp_q;
   logic [14:0] half_q;
   logic        bridgeNew_q;
   logic        sec2New_q;
   logic        wrPend_q;
   logic [7:0]  wrAddr_q;
   logic [31:0] convCnt_q;
   logic [31:0] convLoad;
   logic [15:0] slotCnt_q;
   seq_type     seq_q;
   logic [14:0] bridgeFn;
   logic [14:0] secondVal;
   logic [14:0] faultLevel;
   logic [14:0] out2Sel;
   logic [5:0]  xzcW;
   logic [5:0]  xzcAbs;
   logic [15:0] totalShift;
   logic        addrPhase;
   logic        seqMode;
   logic [31:0] rdVal;

   assign addrPhase = hsel && hready && htrans[1];
   assign seqMode   = cfg_q[sfe_pkg::CFG_SRC_LSB +: 2] == 2'(sfe_pkg::SRC_SEQ);
   assign bridgeFn  = sfe_pkg::VALUE_MAX - bridge_q;
   assign secondVal = cfg_q[sfe_pkg::CFG_SEQHB_BIT] ? half_q : temp_q;
   assign xzcW      = hwdata[sfe_pkg::CFG_XZC_LSB +: 6];
   assign xzcAbs    = extendedOffsetComp[5] ? 6'(-extendedOffsetComp)
                                            : extendedOffsetComp;
   // [RULE_03] gain-dependent total shift
   assign totalShift = 16'(stepShift(gainSel) * {10'h000, xzcAbs});

   // [RULE_16] open pin (pulled high) means low fault level
   assign faultLevel = fault_band_polarity_pin ? sfe_pkg::FAULT_LOW
                                               : sfe_pkg::FAULT_HIGH;

   // bus: zero wait states, always OKAY
   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         hreadyout <= 1'b0;
         hresp     <= 1'b0;
      end else if (ce) begin
         hreadyout <= 1'b1;
         hresp     <= 1'b0;
      end
   end

   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         wrPend_q <= 1'b0;
         wrAddr_q <= 8'h00;
      end else if (ce) begin
         wrPend_q <= addrPhase && hwrite;
         wrAddr_q <= haddr[7:0];
      end
   end

   always_comb begin
      case (haddr[7:0])
         sfe_pkg::OFS_CFG:   rdVal = cfg_q;
         sfe_pkg::OFS_DOFS:  rdVal = {16'h0000, dofs_q};
         sfe_pkg::OFS_STAT:  rdVal = {14'h0000, seq_q, 2'b00, adcLast_q};
         sfe_pkg::OFS_SHIFT: rdVal = {stepShift(gainSel), totalShift};
         // [RULE_14] 13-bit readout of conditioned signals
         sfe_pkg::OFS_RDBR:  rdVal = readout13(bridge_q);
         sfe_pkg::OFS_RDTMP: rdVal = readout13(temp_q);
         sfe_pkg::OFS_RDHB:  rdVal = readout13(half_q);
         default:            rdVal = 32'h00000000;
      endcase
   end

   // read data is captured at the address phase and stands in the data phase
   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         hrdata <= 32'h00000000;
      end else if (ce) begin
         hrdata <= (addrPhase && !hwrite) ? rdVal : 32'h00000000;
      end
   end

   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         cfg_q  <= 32'h00000000;
         dofs_q <= 16'h0000;
      end else if (ce && wrPend_q) begin
         if (wrAddr_q == sfe_pkg::OFS_CFG) begin
            cfg_q <= {11'h000, hwdata[20:0]};
         end
         if (wrAddr_q == sfe_pkg::OFS_DOFS) begin
            dofs_q <= hwdata[15:0];
         end
      end
   end

   // analog front-end settings driven from configuration
   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         gainSel            <= 4'h0;
         extendedOffsetComp <= 6'h00;
      end else if (ce && wrPend_q && wrAddr_q == sfe_pkg::OFS_CFG) begin
         // [RULE_01] gain index limited to the table
         gainSel <= (hwdata[sfe_pkg::CFG_GAIN_LSB +: 4] > sfe_pkg::GAIN_LAST)
                    ? sfe_pkg::GAIN_LAST : hwdata[sfe_pkg::CFG_GAIN_LSB +: 4];
         // [RULE_02] step count clamp
         if ($signed(xzcW) < sfe_pkg::XZC_MIN) begin
            extendedOffsetComp <= sfe_pkg::XZC_MIN;
         end else begin
            extendedOffsetComp <= xzcW;
         end
      end
   end

   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         integLen <= 2'(sfe_pkg::INT_10);
         adcRange <= 2'b00;
      end else if (ce) begin
         integLen <= cfg_q[sfe_pkg::CFG_INT_LSB +: 2];
         // [RULE_08] converter input range
         adcRange <= cfg_q[sfe_pkg::CFG_RANGE_LSB +: 2];
      end
   end

   // [RULE_07] sample period from integration length
   always_comb begin
      case (integLen)
         2'(sfe_pkg::INT_10): convLoad = 32'(CYC_INT10 - 1);
         2'(sfe_pkg::INT_9):  convLoad = 32'(CYC_INT9 - 1);
         2'(sfe_pkg::INT_8):  convLoad = 32'(CYC_INT8 - 1);
         2'(sfe_pkg::INT_7):  convLoad = 32'(CYC_INT7 - 1);
         default:             convLoad = 32'(CYC_INT10 - 1);
      endcase
   end

   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         convCnt_q <= 32'h00000000;
         convStart <= 1'b0;
      end else if (ce) begin
         convStart <= convCnt_q == 32'h00000000;
         if (convCnt_q == 32'h00000000 || convCnt_q > convLoad) begin
            convCnt_q <= convLoad;
         end else begin
            convCnt_q <= convCnt_q - 32'h00000001;
         end
      end
   end

   // [RULE_06] last 14-bit conversion result
   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         adcLast_q <= 14'h0000;
      end else if (ce && adcValid) begin
         adcLast_q <= adcRaw;
      end
   end

   // conditioned values, 15-bit fractions
   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         bridge_q    <= 15'h0000;
         temp_q      <= 15'h0000;
         half_q      <= 15'h0000;
         bridgeNew_q <= 1'b0;
         sec2New_q   <= 1'b0;
      end else if (ce) begin
         bridgeNew_q <= bridgeValid;
         sec2New_q   <= bridgeValid || tempValid || halfValid || wrPend_q;
         if (bridgeValid) begin
            // [RULE_05] digital offset removal
            // [RULE_17] result saturated into zero..one
            bridge_q <= applyOffset(bridgeIn, dofs_q);
         end
         if (tempValid) begin
            temp_q <= tempIn;
         end
         if (halfValid) begin
            half_q <= halfIn;
         end
      end
   end

   // [RULE_11] sequential pattern stepping
   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         seq_q     <= SQ_LOW;
         slotCnt_q <= 16'h0000;
      end else if (ce) begin
         if (!seqMode) begin
            seq_q     <= SQ_LOW;
            slotCnt_q <= 16'h0000;
         end else if (slotCnt_q == 16'(SEQ_SLOT - 1)) begin
            slotCnt_q <= 16'h0000;
            case (seq_q)
               SQ_LOW:    seq_q <= SQ_HIGH;
               SQ_HIGH:   seq_q <= SQ_SECOND;
               SQ_SECOND: seq_q <= SQ_BRIDGE;
               // [RULE_18] pattern restarts
               SQ_BRIDGE: seq_q <= SQ_LOW;
               default:   seq_q <= SQ_LOW;
            endcase
         end else begin
            slotCnt_q <= slotCnt_q + 16'h0001;
         end
      end
   end

   // [RULE_10] secondary source selection
   always_comb begin
      case (cfg_q[sfe_pkg::CFG_SRC_LSB +: 2])
         2'(sfe_pkg::SRC_TEMP):      out2Sel = temp_q;
         2'(sfe_pkg::SRC_HALF):      out2Sel = half_q;
         2'(sfe_pkg::SRC_BRIDGE_FN): out2Sel = bridgeFn;
         default: begin
            case (seq_q)
               SQ_LOW:    out2Sel = sfe_pkg::FAULT_LOW;
               SQ_HIGH:   out2Sel = sfe_pkg::FAULT_HIGH;
               SQ_SECOND: out2Sel = secondVal;
               default:   out2Sel = bridgeFn;
            endcase
         end
      endcase
   end

   // [RULE_09] primary channel always fed from the bridge
   assign ch1.sample      = bridge_q;
   assign ch1.sampleValid = bridgeNew_q;
   assign ch1.filtEn      = cfg_q[sfe_pkg::CFG_FILT1_BIT];
   assign ch1.diagEn      = cfg_q[sfe_pkg::CFG_DIAG1_BIT];
   assign ch1.faultActive = faultActive;
   assign ch1.faultLevel  = faultLevel;
   // sequence steps must not be smeared, so the filter is bypassed
   assign ch2.sample      = out2Sel;
   assign ch2.sampleValid = seqMode || sec2New_q;
   assign ch2.filtEn      = cfg_q[sfe_pkg::CFG_FILT2_BIT] && !seqMode;
   assign ch2.diagEn      = cfg_q[sfe_pkg::CFG_DIAG2_BIT];
   assign ch2.faultActive = faultActive;
   assign ch2.faultLevel  = faultLevel;

   out_channel #(.FILT_SHIFT(FILT_SHIFT), .DIAG_CYC(DIAG_CYC)) u_out1 (
      .core_clk (core_clk),
      .arst_n   (arst_n),
      .ce       (ce),
      .ch       (ch1.chan)
   );
   out_channel #(.FILT_SHIFT(FILT_SHIFT), .DIAG_CYC(DIAG_CYC)) u_out2 (
      .core_clk (core_clk),
      .arst_n   (arst_n),
      .ce       (ce),
      .ch       (ch2.chan)
   );

   assign primary_analog_out   = ch1.level;
   assign secondary_analog_out = ch2.level;

   chk_xzc_in_range: assert property (@(posedge core_clk) disable iff (!arst_n)
      $signed(extendedOffsetComp) >= -31 && $signed(extendedOffsetComp) <= 31)
      else $error("offset step count outside range"); // [RULE_02]
   chk_gain_in_table: assert property (@(posedge core_clk) disable iff (!arst_n)
      gainSel <= 4'hc)
      else $error("gain index outside table"); // [RULE_01]
   chk_step_lowest_gain: assert property (@(posedge core_clk)
      disable iff (!arst_n)
      gainSel == 4'hc |-> stepShift(gainSel) == 16'd83)
      else $error("lowest gain step wrong"); // [RULE_03]
   chk_reach_full_steps: assert property (@(posedge core_clk)
      disable iff (!arst_n)
      gainSel == 4'h0 && xzcAbs == 6'd31 |-> totalShift >= 16'd30000)
      else $error("compensation reach too small"); // [RULE_04]
   chk_offset_applied: assert property (@(posedge core_clk)
      disable iff (!arst_n)
      ce && bridgeValid |=> bridge_q == applyOffset($past(bridgeIn), $past(dofs_q)))
      else $error("digital offset not applied"); // [RULE_05]
   chk_adc_capture: assert property (@(posedge core_clk) disable iff (!arst_n)
      ce && adcValid |=> adcLast_q == $past(adcRaw))
      else $error("conversion result not held"); // [RULE_06]
   chk_fast_rate_period: assert property (@(posedge core_clk)
      disable iff (!arst_n)
      integLen == 2'd3 && ce |-> convLoad == 32'(CYC_INT7 - 1))
      else $error("shortest integration period wrong"); // [RULE_07]
   chk_seq_order: assert property (@(posedge core_clk) disable iff (!arst_n)
      ce && seqMode && seq_q == SQ_LOW && slotCnt_q == 16'(SEQ_SLOT - 1)
      |=> seq_q == SQ_HIGH)
      else $error("sequence does not go low to high"); // [RULE_11]
   chk_seq_restart: assert property (@(posedge core_clk) disable iff (!arst_n)
      ce && seqMode && seq_q == SQ_BRIDGE && slotCnt_q == 16'(SEQ_SLOT - 1)
      |=> seq_q == SQ_LOW)
      else $error("sequence does not restart"); // [RULE_18]
   chk_fault_polarity: assert property (@(posedge core_clk)
      disable iff (!arst_n)
      ce && faultActive && fault_band_polarity_pin
      |=> primary_analog_out == sfe_pkg::FAULT_LOW)
      else $error("open pin did not give low level"); // [RULE_16]
   chk_bridge_readout: assert property (@(posedge core_clk)
      disable iff (!arst_n)
      ce && addrPhase && !hwrite && haddr[7:0] == sfe_pkg::OFS_RDBR
      |=> hrdata == {19'h00000, $past(bridge_q[14:2])})
      else $error("bridge readout wrong"); // [RULE_14]
endmodule : sensor_frontend_output_control

//--- ecu_model.sv
// control unit model taking the two analog outputs, reading only the secondary for frame sync
`timescale 1ns/10ps
module ecu_model (
   input  wire logic        core_clk,
   input  wire logic        tieLow,
   input  wire logic [14:0] primary_analog_out,
   input  wire logic [14:0] secondary_analog_out,
   output logic             fault_band_polarity_pin,
   output logic             seqSync
);
   logic prevLow_q;
   // pin wiring
   // the pin has a pull-up, so an open pin reads high
   assign fault_band_polarity_pin = tieLow ? 1'b0 : 1'b1;
   // frame sync
   // a low level followed by a high level marks the start of a frame
   always_ff @(posedge core_clk) begin
      prevLow_q <= (secondary_analog_out === sfe_pkg::FAULT_LOW);
   end
   assign seqSync = prevLow_q && (secondary_analog_out === sfe_pkg::FAULT_HIGH);
endmodule : ecu_model

//--- sensor_frontend_output_control_bench.sv
// self-checking bench for the sensor front-end output control block
`timescale 1ns/10ps
`define CHK(g, e) begin num_checks++; if ((g) !== (e)) begin fails++; \
   $display("wrong value %0t: got %h exp %h", $time, g, e); end end
module sensor_frontend_output_control_bench;
   logic        core_clk = 1'b0, arst_n = 1'b0, ce = 1'b1, hsel = 1'b0;
   logic        hwrite = 1'b0, faultActive = 1'b0, tieLow = 1'b0;
   logic        bridgeValid = 1'b0, tempValid = 1'b0, halfValid = 1'b0;
   logic        adcValid = 1'b0, hreadyout, hresp, convStart, pin, seqSync;
   logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, rd;
   logic [1:0]  htrans = 2'h0, integLen, adcRange;
   logic [14:0] bridgeIn = 15'h0, tempIn = 15'h0, halfIn = 15'h0, out1, out2;
   logic [13:0] adcRaw = 14'h0;
   logic [2:0]  hsize = 3'h0;
   logic [3:0]  gainSel;
   logic [5:0]  offComp;
   logic [14:0] seqExp [4] = '{sfe_pkg::FAULT_HIGH, 15'h0abc, 15'h6dcb,
                               sfe_pkg::FAULT_LOW};
   int          fails = 0, num_checks = 0, convCount = 0, i, k;
   int          shiftTbl [13] = '{1250, 760, 1250, 760, 1250, 760, 1250,
                                  760, 520, 1250, 760, 520, 83};
   int          periodTbl [4] = '{50, 40, 30, 20};

   always #4 core_clk = ~core_clk;
   always @(negedge core_clk) if (convStart === 1'b1) convCount++;

   sensor_frontend_output_control #(.CYC_INT10(50), .CYC_INT9(40),
      .CYC_INT8(30), .CYC_INT7(20), .SEQ_SLOT(8)) i_dut (
      .core_clk(core_clk), .arst_n(arst_n), .ce(ce),
      .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
      .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
      .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
      .bridgeIn(bridgeIn), .bridgeValid(bridgeValid), .tempIn(tempIn),
      .tempValid(tempValid), .halfIn(halfIn), .halfValid(halfValid),
      .adcRaw(adcRaw), .adcValid(adcValid), .faultActive(faultActive),
      .fault_band_polarity_pin(pin), .gainSel(gainSel),
      .extendedOffsetComp(offComp), .integLen(integLen),
      .adcRange(adcRange), .convStart(convStart),
      .primary_analog_out(out1), .secondary_analog_out(out2));

   ecu_model i_ecu (.core_clk(core_clk), .tieLow(tieLow),
      .primary_analog_out(out1), .secondary_analog_out(out2),
      .fault_band_polarity_pin(pin), .seqSync(seqSync));

   // hready and hrdata are read at the edge, before the slave updates them
   task automatic bus(input logic w, input logic [7:0] a,
                      input logic [31:0] wd);
      hsel <= 1'b1; haddr <= {24'h0, a}; htrans <= 2'h2; hwrite <= w;
      hsize <= 3'h2;
      do @(posedge core_clk); while (hreadyout !== 1'b1);
      hsel <= 1'b0; htrans <= 2'h0; hwdata <= wd;
      do @(posedge core_clk); while (hreadyout !== 1'b1);
      rd = hrdata;
   endtask : bus

   task automatic smp(input int s, input logic [14:0] v);
      case (s)
         0: begin bridgeIn <= v; bridgeValid <= 1'b1; end
         1: begin tempIn <= v; tempValid <= 1'b1; end
         2: begin halfIn <= v; halfValid <= 1'b1; end
         default: begin adcRaw <= v[13:0]; adcValid <= 1'b1; end
      endcase
      @(posedge core_clk);
      case (s)
         0: bridgeValid <= 1'b0;
         1: tempValid <= 1'b0;
         2: halfValid <= 1'b0;
         default: adcValid <= 1'b0;
      endcase
   endtask : smp

   task automatic wt(input int n);
      repeat (n) @(posedge core_clk);
      #2;
   endtask : wt

   task automatic fin(input string s);
      $display("test %s done", s);
   endtask : fin

   task conclude;
      $display("checks %0d mismatches %0d", num_checks, fails);
      if (fails == 0 && num_checks > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask : conclude

   initial begin
      repeat (30000) @(posedge core_clk);
      fails++;
      conclude();
   end

   initial begin
      repeat (20) @(posedge core_clk);
      arst_n <= 1'b1;
      do @(negedge core_clk); while (hreadyout !== 1'b1);
      @(posedge core_clk);
      bus(1'b0, sfe_pkg::OFS_CFG, 32'h0);
      `CHK(rd, 32'h0)
      bus(1'b1, 8'h1c, 32'hffffffff);
      bus(1'b0, 8'h1c, 32'h0);
      `CHK(rd, 32'h0)
      // gain 15 and step -32 are both out of range
      bus(1'b1, sfe_pkg::OFS_CFG, 32'h00002e0f);
      bus(1'b0, sfe_pkg::OFS_CFG, 32'h0);
      wt(2);
      `CHK(rd, 32'h00002e0f)
      `CHK(gainSel, 4'hc)
      `CHK(offComp, 6'h21)
      `CHK({integLen, adcRange}, 4'he)
      fin("config");
      for (k = 0; k < 13; k++) begin
         bus(1'b1, sfe_pkg::OFS_CFG, 32'h1f0 | k);
         bus(1'b0, sfe_pkg::OFS_SHIFT, 32'h0);
         `CHK(rd, {shiftTbl[k][15:0], 16'(shiftTbl[k] * 31)})
      end
      bus(1'b1, sfe_pkg::OFS_CFG, 32'h1f0);
      bus(1'b0, sfe_pkg::OFS_SHIFT, 32'h0);
      `CHK(rd[15:0] >= 16'd30000, 1'b1)
      fin("step");
      // bridge codes kept inside 10..90 percent of full scale
      smp(0, 15'h1234); smp(1, 15'h0abc); smp(2, 15'h0555); smp(3, 15'h2abc);
      wt(5);
      `CHK(out1, 15'h1234)
      bus(1'b0, sfe_pkg::OFS_RDBR, 32'h0);
      `CHK(rd, 32'h48d)
      bus(1'b0, sfe_pkg::OFS_RDTMP, 32'h0);
      `CHK(rd, 32'h2af)
      bus(1'b0, sfe_pkg::OFS_RDHB, 32'h0);
      `CHK(rd, 32'h155)
      bus(1'b0, sfe_pkg::OFS_STAT, 32'h0);
      `CHK(rd[13:0], 14'h2abc)
      bus(1'b1, sfe_pkg::OFS_DOFS, 32'h34); smp(0, 15'h1234); wt(5);
      `CHK(out1, 15'h1200)
      bus(1'b1, sfe_pkg::OFS_DOFS, 32'h2000); smp(0, 15'h1234); wt(5);
      `CHK(out1, 15'h0)
      bus(1'b1, sfe_pkg::OFS_DOFS, 32'h0); smp(0, 15'h1234); wt(5);
      fin("samples");
      for (k = 0; k < 3; k++) begin
         bus(1'b1, sfe_pkg::OFS_CFG, k << 14);
         wt(6);
         `CHK(out2, k == 1 ? 15'h0555 : seqExp[k / 2 + 1])
      end
      bus(1'b1, sfe_pkg::OFS_CFG, 32'h0000c000);
      i = 0;
      while (seqSync !== 1'b1 && i < 200) begin @(negedge core_clk); i++; end
      `CHK(seqSync, 1'b1)
      for (k = 0; k < 4; k++) begin
         repeat (k == 0 ? 4 : 8) @(negedge core_clk);
         `CHK(out2, seqExp[k])
      end
      @(posedge core_clk);
      fin("sequence");
      faultActive <= 1'b1; wt(4);
      `CHK({out1, out2}, {2{sfe_pkg::FAULT_LOW}})
      tieLow <= 1'b1; wt(4);
      `CHK({out1, out2}, {2{sfe_pkg::FAULT_HIGH}})
      faultActive <= 1'b0; tieLow <= 1'b0; wt(1);
      fin("fault");
      for (k = 0; k < 4; k++) begin
         bus(1'b1, sfe_pkg::OFS_CFG, k << 10); wt(2);
         convCount = 0;
         wt(10 * periodTbl[k]);
         `CHK(convCount >= 9 && convCount <= 11, 1'b1)
      end
      fin("rate");
      bus(1'b1, sfe_pkg::OFS_CFG, 32'h00020000); smp(0, 15'h7000); wt(3);
      `CHK(out1, 15'h1ded)
      fin("filter");
      arst_n <= 1'b0; wt(2); arst_n <= 1'b1;
      bus(1'b1, sfe_pkg::OFS_CFG, 32'h00080000); wt(1100);
      `CHK(out1, sfe_pkg::FAULT_HIGH)
      fin("diag");
      conclude();
   end
endmodule : sensor_frontend_output_control_bench
